// file: tcs_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// temperature conversion sequencer with apb register access
// ------------------------------------------------------------
module tcs_top #(
	parameter int POWERUP_CYC_P = tcs_pkg::POWERUP_CYC,
	parameter int CONV_CYC_P    = tcs_pkg::CONV_CYC,
	parameter int MS_CYC_P      = tcs_pkg::CLK_HZ / 1000,
	// averaging counts as log2 for codes 10 and 11
	parameter logic [2:0] AVG_LOG2_2 = 3'h5,
	parameter logic [2:0] AVG_LOG2_3 = 3'h6,
	// cycle period in ms per code 0..7
	parameter int CYC_MS_0 = 16,
	parameter int CYC_MS_1 = 125,
	parameter int CYC_MS_2 = 250,
	parameter int CYC_MS_3 = 500,
	parameter int CYC_MS_4 = tcs_pkg::CYCLE_1S_MS,
	parameter int CYC_MS_5 = 4000,
	parameter int CYC_MS_6 = 8000,
	parameter int CYC_MS_7 = 16000,
	parameter logic BOOT_SHUTDOWN = 1'b0
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [15:0] adc_sample,
	input  wire logic        serial_clk,
	output logic             alert_out,
	output logic             alert_oe,
	output logic             analog_en
);
	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	initial begin
		if (CONV_CYC_P < 1 || POWERUP_CYC_P < 1 || MS_CYC_P < 1) $error("counts must be >= 1");
		if (AVG_LOG2_2 > 3'h7 || AVG_LOG2_3 > 3'h7) $error("averaging too deep");
	end
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	tcs_pkg::tcs_state_e state_ff, nxt_state;
	logic [15:0] result_ff;
	logic [15:0] lim_lo_ff, lim_hi_ff;
	logic [1:0]  conv_mode_sel_ff;
	logic [2:0]  cycle_period_sel_ff;
	logic [1:0]  avg_count_sel_ff;
	logic        fresh_to_pin_sel_ff;
	logic        ready_ff;
	logic        first_done_ff;
	logic        oneshot_ff;
	logic [31:0] tmr_ff;
	logic [31:0] cyc_ff;
	logic [7:0]  nconv_ff;
	logic        sclk_s;
	logic        sclk_d_ff;
	logic [15:0] sample_ff;
	logic [15:0] mean_w;
	// ------------------------------------------------------------
	// apb decode: access phase with one wait state
	// ------------------------------------------------------------
	// writes land on the edge that sees pready; read side effects on the edge
	// that captures prdata, so a ready flag set in between is never lost
	wire acc_w      = psel & penable;
	wire wr_w       = acc_w & pwrite & pready;
	wire rd_w       = acc_w & ~pwrite & ~pready;
	wire sel_res    = paddr == tcs_pkg::ADDR_RESULT;
	wire sel_cfg    = paddr == tcs_pkg::ADDR_CONFIG;
	wire sel_lo     = paddr == tcs_pkg::ADDR_LIM_LO;
	wire sel_hi     = paddr == tcs_pkg::ADDR_LIM_HI;
	wire sel_st     = paddr == tcs_pkg::ADDR_STATUS;
	wire sel_smp    = paddr == tcs_pkg::ADDR_SAMPLE;
	wire mapped_w   = sel_res | sel_cfg | sel_lo | sel_hi | sel_st | sel_smp;
	wire booting_w  = state_ff == tcs_pkg::TCS_BOOT;
	wire wr_ok_w    = wr_w & ~booting_w;
	wire cfg_wr_w   = wr_ok_w & sel_cfg;
	wire [1:0] wmode_w = pwdata[tcs_pkg::CFG_MODE_LSB +: 2];
	wire sd_wr_w    = cfg_wr_w & (wmode_w == tcs_pkg::MODE_SHUTDOWN);
	wire os_wr_w    = cfg_wr_w & (wmode_w == tcs_pkg::MODE_ONESHOT)
	                  & (state_ff == tcs_pkg::TCS_IDLE);
	wire clr_rdy_w  = rd_w & (sel_cfg | sel_res);
	wire [15:0] cfg_w = {2'h0, ready_ff, 1'b0, conv_mode_sel_ff, cycle_period_sel_ff,
	                     avg_count_sel_ff, 2'h0, fresh_to_pin_sel_ff, 2'h0};
	wire continuous_run_mode = (conv_mode_sel_ff == tcs_pkg::MODE_CONT)
	                         | (conv_mode_sel_ff == tcs_pkg::MODE_CONT_ALT);
	wire power_down_mode   = conv_mode_sel_ff == tcs_pkg::MODE_SHUTDOWN;
	wire single_shot_mode  = oneshot_ff;
	wire [31:0] rd_mux_w = sel_res ? {16'h0, result_ff} :
	                       sel_cfg ? {16'h0, cfg_w} :
	                       sel_lo  ? {16'h0, lim_lo_ff} :
	                       sel_hi  ? {16'h0, lim_hi_ff} :
	                       sel_st  ? {28'h0, first_done_ff, booting_w, power_down_mode,
	                                  single_shot_mode} :
	                       sel_smp ? {16'h0, sample_ff} : 32'h0;
	// ------------------------------------------------------------
	// averaging count: code 00 one, 01 eight, others parameters
	// ------------------------------------------------------------
	wire [2:0] avg_log2_w = (avg_count_sel_ff == 2'h0) ? 3'h0 :
	                        (avg_count_sel_ff == 2'h1) ? 3'h3 :
	                        (avg_count_sel_ff == 2'h2) ? AVG_LOG2_2 : AVG_LOG2_3;
	wire [7:0] nconv_tgt_w = 8'(8'h1 << avg_log2_w);
	// cycle period in pclk cycles per selected code
	logic [31:0] cyc_ms_tab [8];
	generate
		for (genvar i = 0; i < 8; i++) begin : g_cyc
			localparam int MS = (i == 0) ? CYC_MS_0 : (i == 1) ? CYC_MS_1 :
			                    (i == 2) ? CYC_MS_2 : (i == 3) ? CYC_MS_3 :
			                    (i == 4) ? CYC_MS_4 : (i == 5) ? CYC_MS_5 :
			                    (i == 6) ? CYC_MS_6 : CYC_MS_7;
			assign cyc_ms_tab[i] = 32'(MS * MS_CYC_P);
		end
	endgenerate
	wire [31:0] cyc_len_w = cyc_ms_tab[cycle_period_sel_ff];
	// ------------------------------------------------------------
	// sequencer events
	// ------------------------------------------------------------
	wire conv_end_w = (state_ff == tcs_pkg::TCS_ACTIVE)
	                  && (tmr_ff == 32'(CONV_CYC_P - 1));
	// a count written mid-run that the run has already reached ends it at the next conversion end instead of wrapping
	wire run_end_w  = conv_end_w && (nconv_ff >= nconv_tgt_w - 8'h1);
	wire cyc_done_w = cyc_ff >= cyc_len_w - 32'h1;
	// serial clock edges, only a sign of bus activity here
	wire sclk_rise_w = sclk_s & ~sclk_d_ff;
	tcs_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (serial_clk),
		.q       (sclk_s)
	);
	tcs_avg u_avg (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (state_ff != tcs_pkg::TCS_ACTIVE),
		.add     (conv_end_w & ~run_end_w),
		.sample  (sample_ff),
		.shift   (avg_log2_w),
		.mean    (mean_w)
	);
	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tcs_pkg::TCS_BOOT: begin
				if (tmr_ff == 32'(POWERUP_CYC_P - 1))
					nxt_state = BOOT_SHUTDOWN ? tcs_pkg::TCS_IDLE
					                          : tcs_pkg::TCS_ACTIVE;
			end
			tcs_pkg::TCS_IDLE: begin
				if (os_wr_w) nxt_state = tcs_pkg::TCS_ACTIVE;
				else if (cfg_wr_w && wmode_w != tcs_pkg::MODE_SHUTDOWN)
					nxt_state = tcs_pkg::TCS_ACTIVE;
			end
			tcs_pkg::TCS_ACTIVE: begin
				if (sd_wr_w) nxt_state = tcs_pkg::TCS_IDLE;
				else if (run_end_w)
					nxt_state = oneshot_ff ? tcs_pkg::TCS_IDLE
					                       : tcs_pkg::TCS_STANDBY;
			end
			tcs_pkg::TCS_STANDBY: begin
				if (sd_wr_w) nxt_state = tcs_pkg::TCS_IDLE;
				else if (cyc_done_w && continuous_run_mode) nxt_state = tcs_pkg::TCS_ACTIVE;
			end
			default: nxt_state = tcs_pkg::TCS_BOOT;
		endcase
	end
	// ------------------------------------------------------------
	// state, timers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff  <= tcs_pkg::TCS_BOOT;
			tmr_ff    <= 32'h0;
			cyc_ff    <= 32'h0;
			nconv_ff  <= 8'h0;
			sclk_d_ff <= 1'b0;
			sample_ff <= 16'h0;
		end else begin
			state_ff  <= nxt_state;
			sclk_d_ff <= sclk_s;
			sample_ff <= adc_sample; // same-domain converter output
			tmr_ff    <= (nxt_state != state_ff || conv_end_w) ? 32'h0 : tmr_ff + 32'h1;
			// cycle timer spans active plus standby, restarts on a new cycle
			cyc_ff    <= (nxt_state == tcs_pkg::TCS_ACTIVE && state_ff != tcs_pkg::TCS_ACTIVE)
			             ? 32'h0 : cyc_ff + 32'h1;
			nconv_ff  <= (state_ff != tcs_pkg::TCS_ACTIVE) ? 8'h0 :
			             conv_end_w ? nconv_ff + 8'h1 : nconv_ff;
		end
	end
	// ------------------------------------------------------------
	// configuration and limit registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_mode_sel_ff    <= tcs_pkg::MODE_CONT;
			cycle_period_sel_ff <= tcs_pkg::CYCLE_RESET;
			avg_count_sel_ff    <= tcs_pkg::AVG_RESET;
			fresh_to_pin_sel_ff <= 1'b0;
			lim_lo_ff           <= tcs_pkg::LIM_LO_RESET;
			lim_hi_ff           <= tcs_pkg::LIM_HI_RESET;
		end else begin
			if (booting_w && tmr_ff == 32'(POWERUP_CYC_P - 1) && BOOT_SHUTDOWN)
				conv_mode_sel_ff <= tcs_pkg::MODE_SHUTDOWN;
			else if (cfg_wr_w && wmode_w != tcs_pkg::MODE_ONESHOT)
				conv_mode_sel_ff <= wmode_w;
			if (cfg_wr_w) begin
				cycle_period_sel_ff <= pwdata[tcs_pkg::CFG_CYCLE_LSB +: 3];
				avg_count_sel_ff    <= pwdata[tcs_pkg::CFG_AVG_LSB +: 2];
				fresh_to_pin_sel_ff <= pwdata[tcs_pkg::CFG_ROUTE_BIT];
			end
			if (wr_ok_w && sel_lo) lim_lo_ff <= pwdata[15:0];
			if (wr_ok_w && sel_hi) lim_hi_ff <= pwdata[15:0];
		end
	end
	// ------------------------------------------------------------
	// result, data-ready and one-shot tracking
	// ------------------------------------------------------------
	wire set_rdy_w = run_end_w & ~sd_wr_w;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ff     <= tcs_pkg::RESULT_RESET;
			ready_ff      <= 1'b0;
			first_done_ff <= 1'b0;
			oneshot_ff    <= 1'b0;
		end else begin
			if (set_rdy_w) result_ff <= mean_w;
			if (set_rdy_w) first_done_ff <= 1'b1;
			// set wins over a same-cycle read clear
			if (set_rdy_w) ready_ff <= 1'b1;
			else if (clr_rdy_w) ready_ff <= 1'b0;
			if (os_wr_w) oneshot_ff <= 1'b1;
			else if (nxt_state == tcs_pkg::TCS_IDLE) oneshot_ff <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// apb response and pins
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata    <= 32'h0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			alert_out <= 1'b0;
			alert_oe  <= 1'b0;
			analog_en <= 1'b0;
		end else begin
			// one wait state: answer registered in the first access cycle
			pready    <= psel & penable & ~pready;
			pslverr   <= psel & penable & ~pready & ~mapped_w;
			prdata    <= (psel & ~pwrite) ? rd_mux_w : 32'h0;
			alert_out <= 1'b0;
			// open drain: pull low while ready is routed and set
			alert_oe  <= fresh_to_pin_sel_ff & (set_rdy_w | (ready_ff & ~clr_rdy_w));
			analog_en <= nxt_state == tcs_pkg::TCS_ACTIVE;
		end
	end
	// serial link shifts msb byte first; engine lives outside this block
	wire unused_w = sclk_rise_w;
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_boot_end;
		booting_w ##1 !booting_w;
	endsequence
	a_boot_len: assert property (@(posedge pclk) disable iff (!presetn)
		s_boot_end |-> $past(tmr_ff) == 32'(POWERUP_CYC_P - 1))
		else $error("boot left early");
	a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!first_done_ff |-> result_ff == tcs_pkg::RESULT_RESET)
		else $error("result changed before first conversion");
	a_result_when: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(result_ff) |-> $past(set_rdy_w))
		else $error("result changed outside run end");
	a_ready_set: assert property (@(posedge pclk) disable iff (!presetn)
		set_rdy_w |=> ready_ff)
		else $error("ready not set");
	a_ready_clear: assert property (@(posedge pclk) disable iff (!presetn)
		clr_rdy_w && !set_rdy_w |=> !ready_ff)
		else $error("ready not cleared");
	a_sd_abort: assert property (@(posedge pclk) disable iff (!presetn)
		sd_wr_w && !booting_w |=> state_ff == tcs_pkg::TCS_IDLE && !analog_en)
		else $error("shutdown did not abort");
	a_oneshot_end: assert property (@(posedge pclk) disable iff (!presetn)
		run_end_w && oneshot_ff && !sd_wr_w |=> state_ff == tcs_pkg::TCS_IDLE)
		else $error("one-shot did not return");
	a_boot_nowr: assert property (@(posedge pclk) disable iff (!presetn)
		booting_w && wr_w |=> $stable(lim_hi_ff) && $stable(lim_lo_ff))
		else $error("write taken during boot");
	a_alert_route: assert property (@(posedge pclk) disable iff (!presetn)
		!fresh_to_pin_sel_ff |=> !alert_oe || $past(fresh_to_pin_sel_ff))
		else $error("alert driven while not routed");
	// ------------------------------------------------------------
	// sequencing assertions
	// ------------------------------------------------------------
	sequence s_standby_wrap;
		state_ff == tcs_pkg::TCS_STANDBY && cyc_done_w && continuous_run_mode && !sd_wr_w;
	endsequence
	sequence s_alt_start;
		state_ff == tcs_pkg::TCS_IDLE && cfg_wr_w && wmode_w == tcs_pkg::MODE_CONT_ALT;
	endsequence
	// boot ends where the stored default says
	a_boot_target: assert property (@(posedge pclk) disable iff (!presetn)
		s_boot_end |-> state_ff == (BOOT_SHUTDOWN ? tcs_pkg::TCS_IDLE : tcs_pkg::TCS_ACTIVE))
		else $error("boot ended in the wrong state");
	// converter power follows the active state exactly
	a_en_state: assert property (@(posedge pclk) disable iff (!presetn)
		analog_en == (state_ff == tcs_pkg::TCS_ACTIVE))
		else $error("converter power out of step");
	// a finished period starts the next cycle with a fresh cycle timer
	a_cycle_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		s_standby_wrap |=> state_ff == tcs_pkg::TCS_ACTIVE && cyc_ff == 32'h0)
		else $error("cycle did not restart");
	// mode code 10 starts conversions from shutdown like code 00
	a_alt_start: assert property (@(posedge pclk) disable iff (!presetn)
		s_alt_start |=> state_ff == tcs_pkg::TCS_ACTIVE && continuous_run_mode)
		else $error("mode 10 did not run");
	// a one-shot run never enters standby
	a_oneshot_nostby: assert property (@(posedge pclk) disable iff (!presetn)
		single_shot_mode && state_ff == tcs_pkg::TCS_ACTIVE |=> state_ff != tcs_pkg::TCS_STANDBY)
		else $error("one-shot entered standby");
	// ready only falls on a host read
	a_ready_keep: assert property (@(posedge pclk) disable iff (!presetn)
		ready_ff && !clr_rdy_w |=> ready_ff)
		else $error("ready lost without a read");
	// result and first-done flag move together at a run end
	a_result_load: assert property (@(posedge pclk) disable iff (!presetn)
		set_rdy_w |=> first_done_ff && result_ff == $past(mean_w))
		else $error("run end did not publish the mean");
	// pin shows nothing but the routed ready flag
	a_alert_src: assert property (@(posedge pclk) disable iff (!presetn)
		alert_oe |-> ready_ff)
		else $error("alert without ready");
	a_alert_on: assert property (@(posedge pclk) disable iff (!presetn)
		ready_ff && $past(fresh_to_pin_sel_ff) |-> alert_oe)
		else $error("routed ready not on the pin");
	// every answer is a single-cycle pulse
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready stood too long");
endmodule
`default_nettype wire

// file: tcs_pkg.sv
// Function
// - wait a fixed power-up interval before the first conversion
// - result reads the most negative code until the first single conversion or averaging run ends
// - result loads only when a single conversion or averaging run ends
// - result is 16-bit two's complement, one lsb is 7.8125 millidegrees
// - low and high limit registers use the result encoding
// - continuous cycle is an active period then a standby period
// - cycle-period and averaging fields set active and standby lengths
// - averaging runs the set number of conversions and publishes the mean
// - one conversion lasts a fixed time, active time scales with count
// - defaults average eight conversions and repeat once per second
// - mode code 00 runs cycles back to back, updating each time
// - each continuous result sets the data-ready flag
// - reading configuration or result clears the data-ready flag
// - routing bit set puts the data-ready flag on the alert pin
// - writing shutdown code aborts any conversion and powers down
// - in shutdown, code 11 runs one conversion or averaging run then returns to shutdown
// - one-shot has no standby, its length depends only on averaging
// - one-shot completion sets data-ready, cleared by the same reads
// - a stored power-up default can start the device in shutdown
// - during power-up writes are ignored, reads still answered
// - serial transfer sends most significant byte first; here serial_clk is only synchronised, no data is shifted
package tcs_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_RESULT  = 12'h000;
	localparam logic [11:0] ADDR_CONFIG  = 12'h004;
	localparam logic [11:0] ADDR_LIM_LO  = 12'h008;
	localparam logic [11:0] ADDR_LIM_HI  = 12'h00c;
	localparam logic [11:0] ADDR_STATUS  = 12'h010;
	localparam logic [11:0] ADDR_SAMPLE  = 12'h014;
	// ------------------------------------------------------------
	// configuration fields
	// ------------------------------------------------------------
	localparam int CFG_MODE_LSB   = 10;
	localparam int CFG_CYCLE_LSB  = 7;
	localparam int CFG_AVG_LSB    = 5;
	localparam int CFG_ROUTE_BIT  = 2;
	localparam int CFG_READY_BIT  = 13;
	localparam logic [1:0] MODE_CONT     = 2'h0;
	localparam logic [1:0] MODE_SHUTDOWN = 2'h1;
	localparam logic [1:0] MODE_CONT_ALT = 2'h2;
	localparam logic [1:0] MODE_ONESHOT  = 2'h3;
	localparam logic [2:0] CYCLE_RESET   = 3'h4;
	localparam logic [1:0] AVG_RESET     = 2'h1;
	localparam logic [15:0] RESULT_RESET = 16'h8000;
	localparam logic [15:0] LIM_LO_RESET = 16'h8000;
	localparam logic [15:0] LIM_HI_RESET = 16'h7fff;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ         = 40_000_000;
	localparam int POWERUP_US     = 1500;
	localparam int CONV_US        = 15500;
	localparam int POWERUP_CYC    = POWERUP_US * (CLK_HZ / 1_000_000);
	localparam int CONV_CYC       = CONV_US * (CLK_HZ / 1_000_000);
	localparam int CYCLE_1S_MS    = 1000;
	typedef enum logic [1:0] {TCS_BOOT, TCS_IDLE, TCS_ACTIVE, TCS_STANDBY} tcs_state_e;
endpackage

// file: tcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; first stage feeds only the second
module tcs_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic d,
	output logic      q
);
	logic meta_ff;
	// ------------------------------------------------------------
	// synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 1'b0;
			q       <= 1'b0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// file: tcs_avg.sv
`timescale 1ns/1ps
`default_nettype none
// accumulator for averaging runs; mean by shift since counts are powers of two
module tcs_avg #(
	parameter int ACC_W = 24
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clear,
	input  wire logic              add,
	input  wire logic signed [15:0] sample,
	input  wire logic [2:0]        shift,
	output logic signed [15:0]     mean
);
	logic signed [ACC_W-1:0] acc_ff;
	logic signed [ACC_W-1:0] nxt_acc;
	logic signed [ACC_W-1:0] sum_w;
	initial begin
		if (ACC_W < 23) $error("ACC_W too small for 128 samples");
	end
	// ------------------------------------------------------------
	// accumulate
	// ------------------------------------------------------------
	assign sum_w   = acc_ff + ACC_W'(sample);
	assign nxt_acc = clear ? '0 : (add ? sum_w : acc_ff);
	assign mean    = 16'(sum_w >>> shift); // mean includes the final sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) acc_ff <= '0;
		else acc_ff <= nxt_acc;
	end
endmodule
`default_nettype wire

// file: tcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host side model: apb master plus serial clock
// ------------------------------------------------------------
module tcs_host_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             serial_clk
);
	logic frame;
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		frame = 1'b0;
		serial_clk = 1'b0;
	end
	// serial clock only toggles inside a transfer, stands low otherwise
	always #100 serial_clk = frame ? ~serial_clk : 1'b0;
	// one apb transfer; request held until pready is seen at an edge
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		frame <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the bench's hang guard ends a stalled wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		frame <= 1'b0;
		// released lines show the inverse so stale values are not trusted
		paddr <= ~a;
		pwdata <= ~wd;
	endtask
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// self-checking bench, shortened counts
// ------------------------------------------------------------
module tb;
	localparam int CONV = 10;
	localparam int MS   = 5;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] adc_sample;
	logic        serial_clk;
	logic        alert_out;
	logic        alert_oe;
	logic        analog_en;
	logic        sd_en;
	logic [31:0] d;
	logic        e;
	int          fail_count;
	int          cmp_count;
	int          cycles;
	int          c1;
	int          c2;
	tcs_top #(.POWERUP_CYC_P(20), .CONV_CYC_P(CONV), .MS_CYC_P(MS)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_sample(adc_sample),
		.serial_clk(serial_clk), .alert_out(alert_out), .alert_oe(alert_oe),
		.analog_en(analog_en)
	);
	tcs_host_model host_u (
		.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_clk(serial_clk)
	);
	// second copy whose stored default starts it in shutdown
	tcs_top #(.POWERUP_CYC_P(20), .CONV_CYC_P(CONV), .MS_CYC_P(MS),
		.BOOT_SHUTDOWN(1'b1)) dut_sd_u (
		.pclk(pclk), .presetn(presetn), .psel(1'b0), .penable(1'b0),
		.pwrite(1'b0), .paddr(12'h000), .pwdata(32'h0), .prdata(), .pready(),
		.pslverr(), .adc_sample(adc_sample), .serial_clk(serial_clk),
		.alert_out(), .alert_oe(), .analog_en(sd_en)
	);
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		cmp_count++;
		if (got !== ex) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, ex, got);
		end
	endtask
	task automatic rd(input logic [11:0] a);
		host_u.xfer(1'b0, a, 32'h0, d, e);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		host_u.xfer(1'b1, a, v, d, e);
	endtask
	task automatic setadc(input logic [15:0] v);
		@(posedge pclk);
		adc_sample <= v;
	endtask
	// counts settled cycles until analog_en reaches lvl
	task automatic wait_en(input logic lvl, output int n);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (analog_en !== lvl && n < 6000);
	endtask
	// shutdown must keep the converter off for a long stretch
	task automatic quiet();
		c2 = 0;
		repeat (200) begin
			@(negedge pclk);
			if (analog_en !== 1'b0) c2++;
		end
		chk("idle converter", 32'h0, c2);
	endtask
	task automatic t_boot();
		wr(tcs_pkg::ADDR_LIM_LO, 32'h1234);
		rd(tcs_pkg::ADDR_RESULT);
		chk("boot result", 32'h8000, d);
		rd(tcs_pkg::ADDR_CONFIG);
		chk("default config", 32'h220, d);
		rd(tcs_pkg::ADDR_LIM_LO);
		chk("low limit", 32'h8000, d);
		rd(tcs_pkg::ADDR_LIM_HI);
		chk("high limit", 32'h7fff, d);
		rd(12'h018);
		chk("unmapped error", 32'h1, {31'h0, e});
	endtask
	// two halves of an eight-run average with different samples
	task automatic t_default();
		wait_en(1'b0, c1);
		wait_en(1'b1, c1);
		chk("boot to shutdown", 32'h0, {31'h0, sd_en});
		repeat (44) @(negedge pclk);
		setadc(16'h0300);
		wait_en(1'b0, c1);
		chk("eight-run active", CONV * 8 - 44, c1);
		wait_en(1'b1, c2);
		chk("default period", 1000 * MS, c1 + 44 + c2);
		rd(tcs_pkg::ADDR_CONFIG);
		chk("ready set", 32'h1, {31'h0, d[tcs_pkg::CFG_READY_BIT]});
		rd(tcs_pkg::ADDR_CONFIG);
		chk("ready cleared", 32'h0, {31'h0, d[tcs_pkg::CFG_READY_BIT]});
		rd(tcs_pkg::ADDR_RESULT);
		chk("mean", 32'h0200, d);
	endtask
	task automatic t_cycle();
		setadc(16'hf380);
		wr(tcs_pkg::ADDR_CONFIG, 32'h4);
		wait_en(1'b0, c1);
		wait_en(1'b1, c1);
		wait_en(1'b0, c1);
		wait_en(1'b1, c2);
		chk("single active", CONV, c1);
		chk("cycle period", 16 * MS, c1 + c2);
		wait_en(1'b0, c1);
		repeat (2) @(negedge pclk);
		chk("alert on ready", 32'h1, alert_oe);
		rd(tcs_pkg::ADDR_RESULT);
		chk("result", 32'hf380, d);
		@(negedge pclk);
		chk("alert after read", 32'h0, alert_oe);
		chk("alert level", 32'h0, alert_out);
	endtask
	task automatic t_shut();
		wait_en(1'b1, c1);
		setadc(16'h0010);
		wr(tcs_pkg::ADDR_CONFIG, 32'h404);
		repeat (2) @(negedge pclk);
		chk("aborted", 32'h0, analog_en);
		quiet();
		rd(tcs_pkg::ADDR_RESULT);
		chk("result kept", 32'hf380, d);
		for (int a = 0; a < 2; a++) begin
			setadc(16'h3200 + 16'(a));
			wr(tcs_pkg::ADDR_CONFIG, 32'hc04 | (a << 5));
			wait_en(1'b1, c1);
			wait_en(1'b0, c1);
			chk("oneshot active", CONV << (3 * a), c1);
			repeat (2) @(negedge pclk);
			chk("oneshot ready pin", 32'h1, alert_oe);
			rd(tcs_pkg::ADDR_RESULT);
			chk("oneshot result", 32'h3200 + a, d);
			quiet();
		end
	endtask
	task automatic t_mode10();
		setadc(16'hfff0);
		wr(tcs_pkg::ADDR_CONFIG, 32'h800);
		wait_en(1'b1, c1);
		wait_en(1'b0, c1);
		chk("alt mode active", CONV, c1);
		repeat (2) @(negedge pclk);
		rd(tcs_pkg::ADDR_RESULT);
		chk("alt mode result", 32'hfff0, d);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always #12.5 pclk = ~pclk;
	// hang guard, well above the longest expected run
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		adc_sample = 16'h0100;
		fail_count = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_boot();
		t_default();
		t_cycle();
		t_shut();
		t_mode10();
		wrap_up();
	end
endmodule
`default_nettype wire
